// File: logic/phase_timer.v
/*
 * phase timer: counts system clocks since the last clear, saturating at the top.
 * assumes the caller clears it at every phase boundary it measures from.
 */
`timescale 1ns/100ps
`default_nettype none
module phase_timer #(
  parameter CNT_W = 17
) (
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // control and count
  input wire clr,
  output wire [CNT_W-1:0] count
);
  reg [CNT_W-1:0] count_ff;

  always @(posedge sys_clk) begin
    if (!resetn) begin
      count_ff <= {CNT_W{1'b0}};
    end else if (clr) begin
      count_ff <= {CNT_W{1'b0}};
    end else if (count_ff != {CNT_W{1'b1}}) begin
      count_ff <= count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign count = count_ff;
endmodule
`default_nettype wire

// File: logic/swire_consts.vh
/*
 * timing constants, user opcodes and the id-code command of the single-wire bus master.
 * assumes a 200 MHz system clock; all times are in nanoseconds.
 */
`ifndef SWIRE_CONSTS_VH
`define SWIRE_CONSTS_VH

// clock period
`define CLK_PERIOD_NS 5
// least times round up, longest times round down, never below one cycle
`define CYC_MIN(t) ((((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
  (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define CYC_MAX(t) (((t) / `CLK_PERIOD_NS) < 1 ? 1 : ((t) / `CLK_PERIOD_NS))

// line timing in ns (plain defaults, tune for the slave in use)
`define RESET_LOW_DURATION_NS 480000
`define RESET_HIGH_DURATION_NS 480000
`define PRESENCE_SAMPLE_TIME_NS 70000
`define ONE_WRITE_LOW_LIMIT_NS 15000
`define ONE_WRITE_LOW_NS 6000
`define ZERO_WRITE_LOW_MINIMUM_NS 60000
`define READ_LOW_TIME_NS 6000
`define READ_SAMPLE_LATEST_NS 15000
`define READ_SAMPLE_NS 13000
`define SLOT_DURATION_NS 65000
`define SLOT_RECOVERY_TIME_NS 5000

// cycle counts
`define RESET_LOW_CYC `CYC_MIN(`RESET_LOW_DURATION_NS)
`define RESET_HIGH_CYC `CYC_MIN(`RESET_HIGH_DURATION_NS)
`define PRESENCE_SAMPLE_CYC `CYC_MIN(`PRESENCE_SAMPLE_TIME_NS)
`define ONE_WRITE_LOW_CYC `CYC_MAX(`ONE_WRITE_LOW_NS)
`define ZERO_WRITE_LOW_CYC `CYC_MIN(`ZERO_WRITE_LOW_MINIMUM_NS)
`define READ_LOW_CYC `CYC_MIN(`READ_LOW_TIME_NS)
`define READ_SAMPLE_CYC `CYC_MAX(`READ_SAMPLE_NS)
`define SLOT_CYC `CYC_MIN(`SLOT_DURATION_NS)
`define SLOT_RECOVERY_CYC `CYC_MIN(`SLOT_RECOVERY_TIME_NS)

// user opcodes
`define OP_RESET 2'h0
`define OP_WRITE 2'h1
`define OP_READ 2'h2
`define OP_READ_ID 2'h3

// id-code layout and checksum
`define READ_ID_CMD 8'h33
`define CMD_BITS 7'h08
`define ID_BITS 7'h40
`define CRC_POLY 8'h8C
`define CNT_W 17

`endif

// File: logic/swire_master.v
/*
 * single-wire bus master: reset/presence, write and read bit slots, and a whole
 * id-code read (reset, command, 64 read slots, checksum check).
 * assumes an external pull-up on the line and line_in synchronous to sys_clk.
 */
`include "swire_consts.vh"
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - master starts all line activity except presence
// - reset and presence precede the id-code read only; single write and read slots start without one
// - slow-edge master lengthens reset low time
// - master samples presence at fixed time
// - one bit per time slot
// - every slot starts with master falling edge
// - write-one released before one-write limit
// - write-zero held low past minimum
// - recovery time before next slot
// - read slot starts like write-one
// - sample inside the read window
// - short read low, sample late
// - wait full slot after read sample
module swire_master #(
  parameter CNT_W = `CNT_W,
  parameter RESET_LOW_CYC = `RESET_LOW_CYC,
  parameter RESET_HIGH_CYC = `RESET_HIGH_CYC,
  parameter PRESENCE_SAMPLE_CYC = `PRESENCE_SAMPLE_CYC,
  parameter ONE_WRITE_LOW_CYC = `ONE_WRITE_LOW_CYC,
  parameter ZERO_WRITE_LOW_CYC = `ZERO_WRITE_LOW_CYC,
  parameter READ_LOW_CYC = `READ_LOW_CYC,
  parameter READ_SAMPLE_CYC = `READ_SAMPLE_CYC,
  parameter SLOT_CYC = `SLOT_CYC,
  parameter SLOT_RECOVERY_CYC = `SLOT_RECOVERY_CYC
) (
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // user command port
  input wire cmd_valid,
  input wire [1:0] cmd_op,
  input wire cmd_bit,
  output reg cmd_ready_ff,
  // user results
  output reg done_ff,
  output reg presence_ff,
  output reg rd_bit_ff,
  output reg [63:0] id_code_ff,
  output reg crc_ok_ff,
  // single-wire line, open drain
  input wire line_in,
  output reg line_out_ff,
  output reg line_oe_ff
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_RST_LOW = 3'h1;
  localparam [2:0] S_RST_REL = 3'h2;
  localparam [2:0] S_SLOT_LOW = 3'h3;
  localparam [2:0] S_SLOT_HIGH = 3'h4;
  localparam [2:0] S_RECOVER = 3'h5;

  // last count of a phase that lasts cyc clocks, trimmed to the timer width
  function [CNT_W-1:0] last_cyc;
    input integer cyc;
    integer t;
    begin
      t = cyc - 1;
      last_cyc = t[CNT_W-1:0];
    end
  endfunction

  localparam [CNT_W-1:0] RST_LOW_END = last_cyc(RESET_LOW_CYC);
  localparam [CNT_W-1:0] RST_HIGH_END = last_cyc(RESET_HIGH_CYC);
  localparam [CNT_W-1:0] PRES_SMP = last_cyc(PRESENCE_SAMPLE_CYC);
  localparam [CNT_W-1:0] ONE_LOW_END = last_cyc(ONE_WRITE_LOW_CYC);
  localparam [CNT_W-1:0] ZERO_LOW_END = last_cyc(ZERO_WRITE_LOW_CYC);
  localparam [CNT_W-1:0] RD_LOW_END = last_cyc(READ_LOW_CYC);
  localparam [CNT_W-1:0] RD_SMP = last_cyc(READ_SAMPLE_CYC);
  localparam [CNT_W-1:0] SLOT_END = last_cyc(SLOT_CYC);
  localparam [CNT_W-1:0] REC_END = last_cyc(SLOT_RECOVERY_CYC);

  reg [2:0] state_ff;
  reg id_job_ff;
  reg [6:0] bit_idx_ff;
  reg slot_rd_ff;
  reg slot_val_ff;
  reg [7:0] crc_ff;
  reg [CNT_W-1:0] low_end;
  reg tmr_clr;
  wire [CNT_W-1:0] tmr_cnt;

  // reflected checksum step, one bit at a time
  function [7:0] crc_step;
    input [7:0] crc;
    input din;
    reg fb;
    begin
      fb = crc[0] ^ din;
      crc_step = {1'b0, crc[7:1]} ^ ({8{fb}} & `CRC_POLY);
    end
  endfunction

  // the bit that a given slot of the id read carries out
  function cmd_bit_at;
    input [6:0] idx;
    reg [7:0] cmd;
    begin
      cmd = `READ_ID_CMD;
      cmd_bit_at = cmd[idx[2:0]];
    end
  endfunction

  phase_timer #(
    .CNT_W(CNT_W)
  ) u_timer (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clr(tmr_clr),
    .count(tmr_cnt)
  );

  // low phase length of the current slot
  always @* begin
    low_end = ONE_LOW_END;
    if (slot_rd_ff) begin
      low_end = RD_LOW_END;
    end else if (!slot_val_ff) begin
      low_end = ZERO_LOW_END;
    end
  end

  // the timer runs from each phase boundary, except that a slot's high phase goes on counting from the slot's falling edge
  always @* begin
    tmr_clr = 1'b0;
    case (state_ff)
      S_IDLE: tmr_clr = 1'b1;
      S_RST_LOW: tmr_clr = (tmr_cnt == RST_LOW_END);
      S_RST_REL: tmr_clr = (tmr_cnt == RST_HIGH_END);
      S_SLOT_LOW: tmr_clr = 1'b0;
      S_SLOT_HIGH: tmr_clr = (tmr_cnt == SLOT_END);
      S_RECOVER: tmr_clr = (tmr_cnt == REC_END);
      default: tmr_clr = 1'b1;
    endcase
  end

  always @(posedge sys_clk) begin
    if (!resetn) begin
      state_ff <= S_IDLE;
      id_job_ff <= 1'b0;
      bit_idx_ff <= 7'h00;
      slot_rd_ff <= 1'b0;
      slot_val_ff <= 1'b1;
      crc_ff <= 8'h00;
      cmd_ready_ff <= 1'b0;
      done_ff <= 1'b0;
      presence_ff <= 1'b0;
      rd_bit_ff <= 1'b0;
      id_code_ff <= 64'h0000_0000_0000_0000;
      crc_ok_ff <= 1'b0;
      line_out_ff <= 1'b0;
      line_oe_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      line_out_ff <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          line_oe_ff <= 1'b0;
          cmd_ready_ff <= 1'b1;
          if (cmd_valid && cmd_ready_ff) begin
            cmd_ready_ff <= 1'b0;
            id_job_ff <= (cmd_op == `OP_READ_ID);
            bit_idx_ff <= 7'h00;
            crc_ff <= 8'h00;
            slot_rd_ff <= (cmd_op == `OP_READ);
            slot_val_ff <= (cmd_op == `OP_READ) ? 1'b1 : cmd_bit;
            line_oe_ff <= 1'b1;
            if (cmd_op == `OP_RESET || cmd_op == `OP_READ_ID) begin
              presence_ff <= 1'b0;
              state_ff <= S_RST_LOW;
            end else begin
              state_ff <= S_SLOT_LOW;
            end
          end
        end
        S_RST_LOW: begin
          // RESET_LOW_CYC may be raised to cover a slowed falling edge
          if (tmr_cnt == RST_LOW_END) begin
            line_oe_ff <= 1'b0;
            state_ff <= S_RST_REL;
          end
        end
        S_RST_REL: begin
          // slave pulls presence low on its own in this window
          if (tmr_cnt == PRES_SMP) begin
            presence_ff <= !line_in;
          end
          if (tmr_cnt == RST_HIGH_END) begin
            if (id_job_ff && presence_ff) begin
              slot_rd_ff <= 1'b0;
              slot_val_ff <= cmd_bit_at(7'h00);
              line_oe_ff <= 1'b1;
              state_ff <= S_SLOT_LOW;
            end else begin
              done_ff <= 1'b1;
              state_ff <= S_IDLE;
            end
          end
        end
        S_SLOT_LOW: begin
          if (tmr_cnt == low_end) begin
            line_oe_ff <= 1'b0;
            state_ff <= S_SLOT_HIGH;
          end
        end
        S_SLOT_HIGH: begin
          // zero from the slave holds the line low past the release
          if (slot_rd_ff && tmr_cnt == RD_SMP) begin
            rd_bit_ff <= line_in;
            if (id_job_ff) begin
              id_code_ff <= {line_in, id_code_ff[63:1]};
              crc_ff <= crc_step(crc_ff, line_in);
            end
          end
          if (tmr_cnt == SLOT_END) begin
            state_ff <= S_RECOVER;
          end
        end
        S_RECOVER: begin
          if (tmr_cnt == REC_END) begin
            if (id_job_ff && bit_idx_ff != (`CMD_BITS + `ID_BITS - 7'h01)) begin
              bit_idx_ff <= bit_idx_ff + 7'h01;
              slot_rd_ff <= (bit_idx_ff + 7'h01) >= `CMD_BITS;
              slot_val_ff <= ((bit_idx_ff + 7'h01) >= `CMD_BITS) ? 1'b1 :
                cmd_bit_at(bit_idx_ff + 7'h01);
              line_oe_ff <= 1'b1;
              state_ff <= S_SLOT_LOW;
            end else begin
              if (id_job_ff) begin
                crc_ok_ff <= (crc_ff == 8'h00);
              end
              done_ff <= 1'b1;
              state_ff <= S_IDLE;
            end
          end
        end
        default: begin
          line_oe_ff <= 1'b0;
          state_ff <= S_IDLE;
        end
      endcase
    end
  end
  // timing counts all come from parameters; each of the four opcodes ends with a done_ff pulse
endmodule
`default_nettype wire

// File: test/id_slave.sv
/* behavioural serial-id slave on the single-wire line.
   assumes the line reads low only while a party pulls it, sys_clk as time base. */
`timescale 1ns/100ps
`default_nettype none
module id_slave #(
  parameter RESET_MIN = 30,
  parameter PRES_WAIT = 4,
  parameter PRES_LOW = 14,
  parameter WRITE_SAMPLE = 6,
  parameter READ_HOLD = 8
) (
  // time base
  input wire logic sys_clk,
  // line and setup
  input wire logic line,
  input wire logic attach,
  input wire logic [63:0] rom,
  output logic pull
);
  int n;
  int nb;
  int phase;
  logic [7:0] cmd;
  initial begin
    pull = 1'b0;
    phase = 0;
    nb = 0;
    forever begin
      @(negedge line);
      if (phase == 2 && !rom[nb]) begin
        pull <= 1'b1;
        repeat (READ_HOLD) @(posedge sys_clk);
        pull <= 1'b0;
      end
      n = 0;
      while (line === 1'b0 && n < 200) begin
        @(posedge sys_clk);
        n++;
      end
      if (n >= RESET_MIN) begin
        phase = 0;
        nb = 0;
        if (attach) begin
          repeat (PRES_WAIT) @(posedge sys_clk);
          pull <= 1'b1;
          repeat (PRES_LOW) @(posedge sys_clk);
          pull <= 1'b0;
          phase = 1;
        end
      end else if (phase == 1) begin
        cmd[nb] = (n < WRITE_SAMPLE);
        nb++;
        if (nb == 8) begin
          phase = (cmd == 8'h33) ? 2 : 3;
          nb = 0;
        end
      end else if (phase == 2) begin
        nb++;
        if (nb == 64) phase = 3;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/swire_master_sva.sv
/* port checker for the single-wire master.
   assumes the bind below hands on the design's timing parameters. */
`timescale 1ns/100ps
`default_nettype none
module swire_master_sva #(
  parameter RESET_LOW_CYC = 40,
  parameter RESET_HIGH_CYC = 40,
  parameter ONE_WRITE_LOW_CYC = 2,
  parameter ZERO_WRITE_LOW_CYC = 12,
  parameter READ_LOW_CYC = 2,
  parameter SLOT_CYC = 14,
  parameter SLOT_RECOVERY_CYC = 2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // command port
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic cmd_bit,
  input wire logic cmd_ready_ff,
  input wire logic done_ff,
  // line
  input wire logic line_out_ff,
  input wire logic line_oe_ff
);
  localparam int RLM = RESET_LOW_CYC - 1;
  localparam int ZWM = ZERO_WRITE_LOW_CYC - 1;
  localparam int RST_DONE = RESET_LOW_CYC + RESET_HIGH_CYC + 1;
  localparam int SLOT_DONE = SLOT_CYC + SLOT_RECOVERY_CYC + 1;
  logic take;
  assign take = cmd_valid && cmd_ready_ff;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_open_drain; line_out_ff == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");
  property p_idle_quiet; cmd_ready_ff |-> !line_oe_ff; endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("line pulled in idle");
  property p_reset_pulse;
    take && cmd_op == 2'h0 |=> line_oe_ff ##RLM line_oe_ff ##1 !line_oe_ff;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset low length");
  property p_write_one;
    take && cmd_op == 2'h1 && cmd_bit |=> line_oe_ff ##ONE_WRITE_LOW_CYC !line_oe_ff;
  endproperty
  a_write_one: assert property (p_write_one) else $error("write one low length");
  property p_write_zero;
    take && cmd_op == 2'h1 && !cmd_bit |=> line_oe_ff ##ZWM line_oe_ff ##1 !line_oe_ff;
  endproperty
  a_write_zero: assert property (p_write_zero) else $error("write zero low length");
  property p_read_low;
    take && cmd_op == 2'h2 |=> line_oe_ff ##READ_LOW_CYC !line_oe_ff;
  endproperty
  a_read_low: assert property (p_read_low) else $error("read low length");
  property p_reset_done; take && cmd_op == 2'h0 |-> ##RST_DONE done_ff; endproperty
  a_reset_done: assert property (p_reset_done) else $error("reset end time");
  property p_slot_done;
    take && (cmd_op == 2'h1 || cmd_op == 2'h2) |-> ##SLOT_DONE done_ff;
  endproperty
  a_slot_done: assert property (p_slot_done) else $error("slot end time");
  property p_take_busy; take |=> !cmd_ready_ff; endproperty
  a_take_busy: assert property (p_take_busy) else $error("ready after take");
  property p_done_end; done_ff |-> !line_oe_ff ##1 (cmd_ready_ff && !done_ff); endproperty
  a_done_end: assert property (p_done_end) else $error("done not closing");
endmodule
bind swire_master swire_master_sva #(
  .RESET_LOW_CYC(RESET_LOW_CYC), .RESET_HIGH_CYC(RESET_HIGH_CYC),
  .ONE_WRITE_LOW_CYC(ONE_WRITE_LOW_CYC), .ZERO_WRITE_LOW_CYC(ZERO_WRITE_LOW_CYC),
  .READ_LOW_CYC(READ_LOW_CYC), .SLOT_CYC(SLOT_CYC), .SLOT_RECOVERY_CYC(SLOT_RECOVERY_CYC)
) sva (
  .sys_clk(sys_clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
  .cmd_bit(cmd_bit), .cmd_ready_ff(cmd_ready_ff), .done_ff(done_ff),
  .line_out_ff(line_out_ff), .line_oe_ff(line_oe_ff));
`default_nettype wire

// File: test/tb.sv
/* self-checking bench for the single-wire master.
   assumes the behavioural slave, a pulled-up line and shortened timing. */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic cmd_bit = 1'b0;
  logic attach = 1'b1;
  logic [63:0] rom = '0;
  logic [31:0] seed = 32'h2c7a_f701;
  logic cmd_ready_ff, done_ff, presence_ff, rd_bit_ff, crc_ok_ff, line_out_ff, line_oe_ff, pull;
  logic [63:0] id_code_ff;
  wire logic line;
  int failures = 0;
  int total_checks = 0;
  // shortened line timing in clock cycles; also feeds the expected done times
  localparam int RL = 40;
  localparam int RH = 40;
  localparam int PS = 14;
  localparam int W1 = 2;
  localparam int W0 = 12;
  localparam int RDL = 2;
  localparam int RDS = 5;
  localparam int SL = 14;
  localparam int RC = 2;
  localparam int RST_N = RL + RH + 1;
  localparam int SLOT_N = SL + RC + 1;
  localparam int ID_N = RL + RH + 72 * (SL + RC) + 1;
  // pull-up wins unless someone pulls low
  assign line = !(line_oe_ff || pull);
  always #2.5 sys_clk = !sys_clk;
  swire_master #(.RESET_LOW_CYC(RL), .RESET_HIGH_CYC(RH), .PRESENCE_SAMPLE_CYC(PS),
    .ONE_WRITE_LOW_CYC(W1), .ZERO_WRITE_LOW_CYC(W0), .READ_LOW_CYC(RDL), .READ_SAMPLE_CYC(RDS),
    .SLOT_CYC(SL), .SLOT_RECOVERY_CYC(RC)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_bit(cmd_bit), .cmd_ready_ff(cmd_ready_ff), .done_ff(done_ff),
    .presence_ff(presence_ff), .rd_bit_ff(rd_bit_ff), .id_code_ff(id_code_ff),
    .crc_ok_ff(crc_ok_ff), .line_in(line), .line_out_ff(line_out_ff), .line_oe_ff(line_oe_ff));
  id_slave slave (.sys_clk(sys_clk), .line(line), .attach(attach), .rom(rom), .pull(pull));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] crc8(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
    return c;
  endfunction
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic run(input logic [1:0] op, input logic b, input int cyc);
    int n;
    cmd_op <= op;
    cmd_bit <= b;
    cmd_valid <= 1'b1;
    do @(posedge sys_clk); while (cmd_ready_ff !== 1'b1);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (done_ff !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      failures++;
      end_sim();
    end else begin
      chk("done cycles", cyc, n);
    end
  endtask
  task end_sim();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    end_sim();
  end
  initial begin
    logic [63:0] code;
    logic [31:0] r;
    logic [7:0] cmd8;
    logic exp_q[$];
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    for (int a = 1; a >= 0; a--) begin
      attach <= a[0];
      run(2'h0, 1'b0, RST_N);
      chk("presence", a, presence_ff);
    end
    $display("test presence done");
    for (int k = 0; k < 3; k++) begin
      code = {rnd(), rnd()};
      code[63:56] = crc8(code[55:0]) ^ {7'h00, k == 1};
      rom <= code;
      attach <= (k != 2);
      run(2'h3, 1'b0, (k != 2) ? ID_N : RST_N);
      chk("presence", k != 2, presence_ff);
      if (k != 2) begin
        chk("id code", code, id_code_ff);
        chk("checksum ok", k == 0, crc_ok_ff);
      end
    end
    $display("test read id done");
    attach <= 1'b1;
    for (int c = 0; c < 2; c++) begin
      r = rnd();
      cmd8 = (c == 0) ? 8'h33 : (8'h33 ^ (r[7:0] | 8'h01));
      run(2'h0, 1'b0, RST_N);
      for (int i = 0; i < 8; i++) run(2'h1, cmd8[i], SLOT_N);
      // model: a matching command returns the code lsb first, any other leaves the line high
      for (int i = 0; i < 64; i++) exp_q.push_back((c == 0) ? rom[i] : 1'b1);
      for (int i = 0; i < 64; i++) begin
        run(2'h2, 1'b0, SLOT_N);
        chk("read bit", exp_q.pop_front(), rd_bit_ff);
      end
      $display("test slots %0d done", c);
    end
    end_sim();
  end
endmodule
`default_nettype wire
